// ==== pkg/srqc_pkg.sv ====
package srqc_pkg;

    // Register offsets
    localparam logic [7:0] SRQC_ADDR_CHAN_INDEX = 8'h05;
    localparam logic [7:0] SRQC_ADDR_SYNC_CTL = 8'h3a;
    localparam logic [7:0] SRQC_ADDR_REQ_CTL = 8'h3c;
    localparam logic [7:0] SRQC_ADDR_TUNING = 8'h3e;

    // Sync control fields
    localparam int SRQC_SYNC_MASTER_BIT = 0;
    localparam int SRQC_SYNC_DIVIDER_BIT = 1;
    localparam logic [1:0] SRQC_SYNC_CTL_RESET = 2'h0;

    // Requantizer control fields
    localparam int SRQC_REQ_ENABLE_BIT = 0;
    localparam int SRQC_REQ_MODE_LSB = 1;
    localparam int SRQC_REQ_MODE_MSB = 3;
    localparam int SRQC_REQ_PIN_DIS_BIT = 4;
    localparam int SRQC_REQ_CTL_W = 5;
    localparam logic [4:0] SRQC_REQ_CTL_RESET = 5'h00;

    // Tuning word fields
    localparam int SRQC_TUNING_W = 6;
    localparam logic [5:0] SRQC_TUNING_RESET = 6'h1c;

    // Bandwidth mode codes
    localparam logic [2:0] SRQC_MODE_BW22 = 3'h0;
    localparam logic [2:0] SRQC_MODE_BW33 = 3'h1;

    // Number of legal tuning words per mode
    localparam logic [6:0] SRQC_TUNING_COUNT_BW22 = 7'h39;
    localparam logic [6:0] SRQC_TUNING_COUNT_BW33 = 7'h22;

    // Register data width and channel count
    localparam int SRQC_DATA_W = 8;
    localparam int SRQC_NUM_CHANNELS = 4;

endpackage

// ==== design/srqc_sync2.sv ====
`timescale 1ns/100ps
module srqc_sync2 #(
    parameter int WIDTH = 2
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Asynchronous levels in, synchronised levels out
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } srqc_sync2_s;

    srqc_sync2_s st_r;
    srqc_sync2_s st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.stage1 = async_in;
        st_nxt.stage2 = st_r.stage1;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign sync_out = st_r.stage2;
endmodule // srqc_sync2

// ==== design/srqc_sync_requant_ctl.sv ====
// Behaviour
// RL1: Every sync function stays inactive unless master sync enable bit 0 is set.
// RL2: Sync pulse reaches the clock divider only while bits 1 and 0 are high.
// RL3: Software should keep master sync enable low when sync is unused.
// RL4: Select pin drives selected channels when bit 4 is zero, ignored when one.
// RL5: Local register writes affect only channels chosen by the channel index register.
// RL6: Mode bits 3:1 decode 000 as 22% bandwidth, 001 as 33% bandwidth.
// RL7: Enable bit 0 switches the requantizer, honoured only while bit 4 is set.
// RL8: Six-bit tuning word bits 5:0 sets the requantizer band edges.
// RL9: 57 tuning words are valid in 22% mode, 34 in 33% mode.
// RL10: Each tuning word step moves the band by 0.5% of sample rate.
// RL11: Sync control bits 7:2 are reserved and have no function.
// RL12: With bit 4 zero, channel enable follows the select pin level.
`timescale 1ns/100ps
module srqc_sync_requant_ctl
    import srqc_pkg::*;
#(
    parameter int NUM_CH = srqc_pkg::SRQC_NUM_CHANNELS
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Register port from the serial control port decoder
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [7:0] reg_addr,
    input wire logic [srqc_pkg::SRQC_DATA_W-1:0] reg_wdata,
    output logic [srqc_pkg::SRQC_DATA_W-1:0] reg_rdata,
    output logic reg_rd_valid,
    // Device pins
    input wire logic sync_pin,
    input wire logic mode_pin,
    // Sync outputs
    output logic sync_powered,
    output logic divider_sync,
    // Per-channel requantizer settings
    output logic [NUM_CH-1:0] requant_enable,
    output logic [NUM_CH-1:0] requant_bw33,
    output logic [NUM_CH-1:0][srqc_pkg::SRQC_TUNING_W-1:0] tuning_word,
    output logic [NUM_CH-1:0] tuning_valid
);
    import srqc_pkg::*;

    typedef struct packed {
        logic [NUM_CH-1:0] chan_sel;
        logic [1:0] sync_ctl;
        logic [NUM_CH-1:0][SRQC_REQ_CTL_W-1:0] req_ctl;
        logic [NUM_CH-1:0][SRQC_TUNING_W-1:0] tuning;
        logic [NUM_CH-1:0] requant_en;
        logic [NUM_CH-1:0] bw33;
        logic [NUM_CH-1:0] tw_valid;
        logic div_sync;
        logic [SRQC_DATA_W-1:0] rdata;
        logic rd_valid;
    } srqc_state_s;

    srqc_state_s st_r;
    srqc_state_s st_nxt;
    logic [1:0] pin_levels;
    logic sync_level;
    logic mode_level;

    // Pins pass two flip-flops before use
    srqc_sync2 #(
        .WIDTH(2)
    ) u_pin_sync (
        .clk(clk),
        .reset(reset),
        .async_in({mode_pin, sync_pin}),
        .sync_out(pin_levels)
    );

    assign sync_level = pin_levels[0];
    assign mode_level = pin_levels[1];

    // Tuning word legal for the given mode
    function automatic logic tuning_ok(input logic [2:0] mode, input logic [5:0] tw);
        logic ok;
        ok = 1'b0;
        if (mode == SRQC_MODE_BW22) begin
            ok = ({1'b0, tw} < SRQC_TUNING_COUNT_BW22); // see RL9
        end else if (mode == SRQC_MODE_BW33) begin
            ok = ({1'b0, tw} < SRQC_TUNING_COUNT_BW33); // see RL9
        end
        return ok;
    endfunction

    // Lowest selected channel, channel 0 when none
    function automatic int first_sel(input logic [NUM_CH-1:0] sel);
        int idx;
        idx = 0;
        for (int i = NUM_CH - 1; i >= 0; i--) begin
            if (sel[i]) begin
                idx = i;
            end
        end
        return idx;
    endfunction

    always_comb begin
        int rsel;
        logic [2:0] mode;
        rsel = first_sel(st_r.chan_sel);
        mode = '0;
        st_nxt = st_r;
        st_nxt.rd_valid = 1'b0;
        // Register writes
        if (reg_wr_en) begin
            if (reg_addr == SRQC_ADDR_CHAN_INDEX) begin
                st_nxt.chan_sel = reg_wdata[NUM_CH-1:0];
            end else if (reg_addr == SRQC_ADDR_SYNC_CTL) begin
                st_nxt.sync_ctl = reg_wdata[SRQC_SYNC_DIVIDER_BIT:SRQC_SYNC_MASTER_BIT]; // see RL11
            end else if (reg_addr == SRQC_ADDR_REQ_CTL) begin
                for (int ch = 0; ch < NUM_CH; ch++) begin
                    if (st_r.chan_sel[ch]) begin // see RL5
                        st_nxt.req_ctl[ch] = reg_wdata[SRQC_REQ_CTL_W-1:0];
                    end
                end
            end else if (reg_addr == SRQC_ADDR_TUNING) begin
                for (int ch = 0; ch < NUM_CH; ch++) begin
                    if (st_r.chan_sel[ch]) begin // see RL5
                        st_nxt.tuning[ch] = reg_wdata[SRQC_TUNING_W-1:0]; // see RL8
                    end
                end
            end
        end
        // Register reads, local registers from the lowest selected channel
        if (reg_rd_en) begin
            st_nxt.rd_valid = 1'b1;
            if (reg_addr == SRQC_ADDR_CHAN_INDEX) begin
                st_nxt.rdata = SRQC_DATA_W'(st_r.chan_sel);
            end else if (reg_addr == SRQC_ADDR_SYNC_CTL) begin
                st_nxt.rdata = SRQC_DATA_W'(st_r.sync_ctl); // see RL11
            end else if (reg_addr == SRQC_ADDR_REQ_CTL) begin
                st_nxt.rdata = SRQC_DATA_W'(st_r.req_ctl[rsel]);
            end else if (reg_addr == SRQC_ADDR_TUNING) begin
                st_nxt.rdata = SRQC_DATA_W'(st_r.tuning[rsel]);
            end else begin
                st_nxt.rdata = '0;
            end
        end
        // Requantizer settings per channel
        for (int ch = 0; ch < NUM_CH; ch++) begin
            mode = st_r.req_ctl[ch][SRQC_REQ_MODE_MSB:SRQC_REQ_MODE_LSB];
            if (st_r.req_ctl[ch][SRQC_REQ_PIN_DIS_BIT]) begin // see RL4
                st_nxt.requant_en[ch] = st_r.req_ctl[ch][SRQC_REQ_ENABLE_BIT]; // see RL7
            end else begin
                st_nxt.requant_en[ch] = mode_level; // see RL12
            end
            st_nxt.bw33[ch] = (mode == SRQC_MODE_BW33); // see RL6
            st_nxt.tw_valid[ch] = tuning_ok(mode, st_r.tuning[ch]); // see RL9
        end
        // Sync gate to the clock divider
        st_nxt.div_sync = sync_level
            & st_r.sync_ctl[SRQC_SYNC_DIVIDER_BIT]
            & st_r.sync_ctl[SRQC_SYNC_MASTER_BIT]; // see RL1 see RL2
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            st_r.chan_sel <= '1;
            st_r.sync_ctl <= SRQC_SYNC_CTL_RESET;
            st_r.req_ctl <= {NUM_CH{SRQC_REQ_CTL_RESET}};
            st_r.tuning <= {NUM_CH{SRQC_TUNING_RESET}};
            st_r.requant_en <= '0;
            st_r.bw33 <= '0;
            st_r.tw_valid <= '0;
            st_r.div_sync <= 1'b0;
            st_r.rdata <= '0;
            st_r.rd_valid <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs; tuning word counts the band offset in 0.5% steps
    assign reg_rdata = st_r.rdata;
    assign reg_rd_valid = st_r.rd_valid;
    assign sync_powered = st_r.sync_ctl[SRQC_SYNC_MASTER_BIT]; // see RL1 see RL3
    assign divider_sync = st_r.div_sync;
    assign requant_enable = st_r.requant_en;
    assign requant_bw33 = st_r.bw33;
    assign tuning_word = st_r.tuning; // see RL10
    assign tuning_valid = st_r.tw_valid;

    // Checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    sequence s_ctl_write_sel0;
        reg_wr_en && reg_addr == SRQC_ADDR_REQ_CTL && st_r.chan_sel[0];
    endsequence

    sequence s_ctl_write_unsel0;
        reg_wr_en && reg_addr == SRQC_ADDR_REQ_CTL && !st_r.chan_sel[0];
    endsequence

    chk_master_gate_off: assert property ( // see RL1
        !st_r.sync_ctl[SRQC_SYNC_MASTER_BIT] |=> !divider_sync
    ) else $error("divider sync active with master sync disabled");

    chk_divider_sync_pass: assert property ( // see RL2
        (st_r.sync_ctl == 2'h3 && sync_level) |=> divider_sync
    ) else $error("sync pulse not passed with both enables set");

    chk_divider_gate_off: assert property ( // see RL2
        !st_r.sync_ctl[SRQC_SYNC_DIVIDER_BIT] |=> !divider_sync
    ) else $error("divider sync active with divider sync disabled");

    chk_sync_reserved_read: assert property ( // see RL11
        (reg_rd_en && reg_addr == SRQC_ADDR_SYNC_CTL) |=> reg_rd_valid && reg_rdata[7:2] == 6'h00
    ) else $error("reserved sync bits read nonzero");

    chk_local_write_apply: assert property ( // see RL5
        s_ctl_write_sel0 ##1 1'b1 |-> st_r.req_ctl[0] == $past(reg_wdata[4:0])
    ) else $error("selected channel did not take the write");

    chk_local_write_skip: assert property ( // see RL5
        s_ctl_write_unsel0 |=> $stable(st_r.req_ctl[0])
    ) else $error("unselected channel changed on write");

    chk_pin_follow_level: assert property ( // see RL4
        (!st_r.req_ctl[0][SRQC_REQ_PIN_DIS_BIT] && mode_level) |=> requant_enable[0]
    ) else $error("pin high did not enable channel");

    chk_pin_ignored_bit: assert property ( // see RL7
        st_r.req_ctl[0][SRQC_REQ_PIN_DIS_BIT]
            |=> requant_enable[0] == $past(st_r.req_ctl[0][SRQC_REQ_ENABLE_BIT])
    ) else $error("enable bit not honoured with pin disabled");

    chk_mode_decode_bw: assert property ( // see RL6
        st_r.req_ctl[0][3:1] == SRQC_MODE_BW33 |=> requant_bw33[0]
    ) else $error("33 percent mode not decoded");

    chk_tuning_limit: assert property ( // see RL9
        (st_r.req_ctl[0][3:1] == SRQC_MODE_BW33 && st_r.tuning[0] == 6'h22) |=> !tuning_valid[0]
    ) else $error("tuning word 34 accepted in 33 percent mode");

    chk_tuning_top_ok: assert property ( // see RL9
        (st_r.req_ctl[0][3:1] == SRQC_MODE_BW22 && st_r.tuning[0] == 6'h38) |=> tuning_valid[0]
    ) else $error("tuning word 56 refused in 22 percent mode");
endmodule // srqc_sync_requant_ctl

// ==== verif/test_sync_and_requantizer_control.sv ====
`timescale 1ns/100ps
module test_sync_and_requantizer_control;
    import srqc_pkg::*;
    logic clk, reset, reg_wr_en, reg_rd_en, sync_pin, mode_pin;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic reg_rd_valid, sync_powered, divider_sync;
    logic [3:0] requant_enable, requant_bw33, tuning_valid;
    logic [3:0][5:0] tuning_word;
    logic [7:0] exp_q[$];
    logic [7:0] sync_tab[5] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'hfd};
    logic [31:0] seed = 32'h0000b388;
    int fails = 0;
    int samples_checked = 0;
    int cycles = 0;

    srqc_sync_requant_ctl #(.NUM_CH(4)) dut (.clk(clk), .reset(reset), .reg_wr_en(reg_wr_en),
        .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid), .sync_pin(sync_pin),
        .mode_pin(mode_pin), .sync_powered(sync_powered), .divider_sync(divider_sync),
        .requant_enable(requant_enable), .requant_bw33(requant_bw33),
        .tuning_word(tuning_word),
        .tuning_valid(tuning_valid));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        x = x ^ (x << 5);
        return x;
    endfunction

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        $display("checked %0d, mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr_en <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr_en <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_rd_en <= 1'b1;
        reg_addr <= a;
        exp_q.push_back(e);
        @(posedge clk);
        reg_rd_en <= 1'b0;
    endtask

    task automatic settle();
        repeat (4) @(posedge clk);
        @(negedge clk);
    endtask

    task automatic tune(input logic [2:0] m, input logic [5:0] w);
        logic v;
        v = (m == SRQC_MODE_BW22) ? (w < 6'h39) : (m == SRQC_MODE_BW33) ? (w < 6'h22) : 1'b0;
        wr(SRQC_ADDR_REQ_CTL, {3'h0, 1'b1, m, 1'b0});
        wr(SRQC_ADDR_TUNING, {2'h3, w});
        settle();
        check({2'h0, tuning_word[0]}, {2'h0, w});
        check({2'h0, tuning_word[3]}, {2'h0, w});
        check({4'h0, tuning_valid}, {4'h0, {4{v}}});
        check({4'h0, requant_bw33}, {4'h0, {4{m == SRQC_MODE_BW33}}});
        rd(SRQC_ADDR_TUNING, {2'h0, w});
    endtask

    // Read results are matched against the oldest expected value
    always @(negedge clk) begin
        if (reg_rd_valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                check(reg_rdata, 8'hxx);
            end else begin
                check(reg_rdata, exp_q.pop_front());
            end
        end
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            finish_test();
        end
    end

    initial begin
        reset = 1'b1;
        {reg_wr_en, reg_rd_en, sync_pin, mode_pin} = 4'h0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        rd(SRQC_ADDR_SYNC_CTL, 8'h00);
        rd(SRQC_ADDR_REQ_CTL, 8'h00);
        rd(SRQC_ADDR_TUNING, 8'h1c);
        rd(SRQC_ADDR_CHAN_INDEX, 8'h0f);
        rd(8'h40, 8'h00);
        sync_pin <= 1'b1;
        foreach (sync_tab[i]) begin
            wr(SRQC_ADDR_SYNC_CTL, sync_tab[i]);
            settle();
            check({7'h0, sync_powered}, {7'h0, sync_tab[i][0]});
            check({7'h0, divider_sync}, {7'h0, &sync_tab[i][1:0]});
            rd(SRQC_ADDR_SYNC_CTL, sync_tab[i] & 8'h03);
        end
        wr(SRQC_ADDR_SYNC_CTL, 8'h03);
        sync_pin <= 1'b0;
        settle();
        check({7'h0, divider_sync}, 8'h00);
        wr(SRQC_ADDR_SYNC_CTL, 8'h00);
        settle();
        check({7'h0, sync_powered}, 8'h00);
        mode_pin <= 1'b1;
        wr(SRQC_ADDR_REQ_CTL, 8'h00);
        settle();
        check({4'h0, requant_enable}, 8'h0f);
        wr(SRQC_ADDR_REQ_CTL, 8'h10);
        settle();
        check({4'h0, requant_enable}, 8'h00);
        mode_pin <= 1'b0;
        wr(SRQC_ADDR_REQ_CTL, 8'h01);
        settle();
        check({4'h0, requant_enable}, 8'h00);
        wr(SRQC_ADDR_CHAN_INDEX, 8'h05);
        wr(SRQC_ADDR_REQ_CTL, 8'h11);
        wr(SRQC_ADDR_CHAN_INDEX, 8'h0a);
        wr(SRQC_ADDR_REQ_CTL, 8'h12);
        settle();
        check({4'h0, requant_enable}, 8'h05);
        check({4'h0, requant_bw33}, 8'h0a);
        rd(SRQC_ADDR_REQ_CTL, 8'h12);
        wr(SRQC_ADDR_CHAN_INDEX, 8'h0f);
        tune(SRQC_MODE_BW22, 6'h38);
        tune(SRQC_MODE_BW22, 6'h39);
        tune(SRQC_MODE_BW33, 6'h21);
        tune(SRQC_MODE_BW33, 6'h22);
        tune(3'h2, 6'h00);
        for (int k = 0; k < 8; k++) begin
            seed = xs(seed);
            tune({2'h0, seed[8]}, seed[5:0]);
        end
        repeat (3) @(posedge clk);
        check(8'(exp_q.size()), 8'h00);
        finish_test();
    end
endmodule // test_sync_and_requantizer_control
